// [rtl/byte_alu_pkg.sv]
package byte_alu_pkg;

  // register port indexes
  localparam logic [3:0] REG_FLAGS   = 4'h0;
  localparam logic [3:0] REG_RESULT  = 4'h1;
  localparam logic [3:0] REG_LAST_OP = 4'h2;
  localparam logic [3:0] REG_STATUS  = 4'h3;
  localparam logic [3:0] REG_CTRL    = 4'h4;

  // condition flag positions inside the flag register
  localparam int FLAG_C = 7;
  localparam int FLAG_Z = 6;
  localparam int FLAG_S = 5;
  localparam int FLAG_V = 4;
  localparam int FLAG_D = 3;
  localparam int FLAG_H = 2;
  localparam logic [7:0] FLAGS_MASK  = 8'hfc;
  localparam logic [7:0] FLAGS_RESET = 8'h00;

  // status and control bits
  localparam int STAT_BUSY     = 0;
  localparam int STAT_ILLEGAL  = 1;
  localparam int STAT_LAST_ADD = 2;
  localparam int CTRL_ENABLE   = 0;
  localparam logic [7:0] CTRL_RESET = 8'h01;

  // opcode nibbles
  localparam logic [3:0] ADD_HI   = 4'h0;
  localparam logic [3:0] AND_HI   = 4'h5;
  localparam logic [3:0] LO_R_R   = 4'h2;
  localparam logic [3:0] LO_R_IR  = 4'h3;
  localparam logic [3:0] LO_IR_IM = 4'h7;

  // execution lengths in clock cycles
  localparam logic [3:0] CYC_SHORT = 4'h6;
  localparam logic [3:0] CYC_LONG  = 4'ha;

  // upper nibble that marks a working register designator
  localparam logic [3:0] WORKING_NIBBLE = 4'he;

  typedef enum logic {OP_ADD, OP_AND} alu_op_t;
  typedef enum logic {ST_IDLE, ST_EXEC} exec_state_t;

  // returns {is_working, working register number}
  function automatic logic [4:0] wreg_decode(input logic [7:0] addr);
    wreg_decode = {(addr[7:4] == WORKING_NIBBLE), addr[3:0]};
  endfunction

endpackage

// [rtl/alu_opcode_decode.sv]
`timescale 1ns/10ps
module alu_opcode_decode
  import byte_alu_pkg::*;
(
  input  wire logic [7:0] i_opcode,
  output logic            o_valid,
  output alu_op_t         o_op,
  output logic [3:0]      o_cycles,
  output logic            o_dst_short
);

  logic [3:0] hi;
  logic [3:0] lo;

  always_comb begin
    hi          = i_opcode[7:4];
    lo          = i_opcode[3:0];
    o_valid     = ((hi == ADD_HI) || (hi == AND_HI)) && (lo >= LO_R_R) && (lo <= LO_IR_IM);
    o_op        = (hi == AND_HI) ? OP_AND : OP_ADD;
    // working-register forms run short, register forms long
    o_dst_short = (lo <= LO_R_IR);
    o_cycles    = o_dst_short ? CYC_SHORT : CYC_LONG;
  end

endmodule

// [rtl/alu_byte_core.sv]
`timescale 1ns/10ps
module alu_byte_core
  import byte_alu_pkg::*;
(
  input  wire logic [7:0] i_dst,
  input  wire logic [7:0] i_src,
  input  alu_op_t         i_op,
  input  wire logic [7:0] i_flags,
  output logic [7:0]      o_result,
  output logic [7:0]      o_flags
);

  logic [8:0] sum9;
  logic [4:0] low5;

  always_comb begin
    sum9    = {1'b0, i_dst} + {1'b0, i_src};
    low5    = {1'b0, i_dst[3:0]} + {1'b0, i_src[3:0]};
    o_flags = i_flags & FLAGS_MASK;
    if (i_op == OP_ADD) begin
      o_result       = sum9[7:0];
      o_flags[FLAG_C] = sum9[8];
      o_flags[FLAG_S] = sum9[7];
      o_flags[FLAG_V] = (i_dst[7] == i_src[7]) && (sum9[7] != i_dst[7]);
      o_flags[FLAG_D] = 1'b0;
      o_flags[FLAG_H] = low5[4];
    end else begin
      // carry, half-carry and decimal-adjust pass through untouched
      o_result       = i_dst & i_src;
      o_flags[FLAG_S] = o_result[7];
      o_flags[FLAG_V] = 1'b0;
    end
    o_flags[FLAG_Z] = (o_result == 8'h00);
  end

endmodule

// [rtl/byte_add_and_alu.sv]
`timescale 1ns/10ps
module byte_add_and_alu
  import byte_alu_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  // sequencer side
  input  wire logic       i_issue,
  input  wire logic [7:0] i_opcode,
  input  wire logic [7:0] i_dst_addr,
  input  wire logic [7:0] i_src_addr,
  input  wire logic [7:0] i_dst_data,
  input  wire logic [7:0] i_src_data,
  output logic            o_busy,
  output logic            o_done,
  output logic            o_illegal,
  output logic [7:0]      o_wr_addr,
  output logic [7:0]      o_wr_data,
  output logic            o_wr_working,
  output logic [3:0]      o_wr_wnum,
  output logic            o_src_working,
  output logic [3:0]      o_src_wnum,
  output logic [7:0]      o_flags,
  // register port
  input  wire logic [3:0] i_reg_addr,
  input  wire logic [7:0] i_reg_wdata,
  input  wire logic       i_reg_wr,
  input  wire logic       i_reg_rd,
  output logic [7:0]      o_reg_rdata
);

  exec_state_t state;
  logic [3:0]  cnt;
  logic [7:0]  dst_q;
  logic [7:0]  src_q;
  logic [7:0]  dst_addr_q;
  alu_op_t     op_q;
  logic        dst_short_q;
  logic [7:0]  ctrl;
  logic [7:0]  result;
  logic [7:0]  last_op;
  logic        last_add;
  logic        illegal_sticky;

  logic        dec_valid;
  alu_op_t     dec_op;
  logic [3:0]  dec_cycles;
  logic        dec_dst_short;
  logic [7:0]  core_result;
  logic [7:0]  core_flags;

  logic        offer;
  logic        take_ok;
  logic        take_bad;
  logic        finish;
  logic [4:0]  dst_dec;
  logic [4:0]  src_dec;

  alu_opcode_decode u_decode (
    .i_opcode    (i_opcode),
    .o_valid     (dec_valid),
    .o_op        (dec_op),
    .o_cycles    (dec_cycles),
    .o_dst_short (dec_dst_short)
  );

  alu_byte_core u_core (
    .i_dst    (dst_q),
    .i_src    (src_q),
    .i_op     (op_q),
    .i_flags  (o_flags),
    .o_result (core_result),
    .o_flags  (core_flags)
  );

  always_comb begin
    offer    = i_issue && (state == ST_IDLE) && ctrl[CTRL_ENABLE];
    take_ok  = offer && dec_valid;
    take_bad = offer && !dec_valid;
    finish   = (state == ST_EXEC) && (cnt == 4'h0);
    dst_dec  = wreg_decode(dst_addr_q);
    src_dec  = wreg_decode(i_src_addr);
  end

  // execution sequencing: the count runs the documented instruction length
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      state  <= ST_IDLE;
      cnt    <= 4'h0;
      o_busy <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (take_ok) begin
            state  <= ST_EXEC;
            cnt    <= dec_cycles - 4'h1;
            o_busy <= 1'b1;
          end
        end
        ST_EXEC: begin
          if (cnt == 4'h0) begin
            state  <= ST_IDLE;
            o_busy <= 1'b0;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        default: begin
          state  <= ST_IDLE;
          o_busy <= 1'b0;
        end
      endcase
    end
  end

  // operand capture at issue
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      dst_q         <= 8'h00;
      src_q         <= 8'h00;
      dst_addr_q    <= 8'h00;
      op_q          <= OP_ADD;
      dst_short_q   <= 1'b0;
      last_op       <= 8'h00;
      o_src_working <= 1'b0;
      o_src_wnum    <= 4'h0;
    end else if (take_ok) begin
      dst_q         <= i_dst_data;
      src_q         <= i_src_data;
      dst_addr_q    <= i_dst_addr;
      op_q          <= dec_op;
      dst_short_q   <= dec_dst_short;
      last_op       <= i_opcode;
      o_src_working <= dec_dst_short | src_dec[4];
      o_src_wnum    <= src_dec[3:0];
    end
  end

  // result write-back goes to the destination only; source is never written
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_done       <= 1'b0;
      o_wr_addr    <= 8'h00;
      o_wr_data    <= 8'h00;
      o_wr_working <= 1'b0;
      o_wr_wnum    <= 4'h0;
      result       <= 8'h00;
      last_add     <= 1'b0;
    end else begin
      o_done <= finish;
      if (finish) begin
        o_wr_data <= core_result;
        result    <= core_result;
        last_add  <= (op_q == OP_ADD);
        if (dst_short_q) begin
          // short forms carry a bare 4-bit register number
          o_wr_addr    <= {WORKING_NIBBLE, dst_addr_q[3:0]};
          o_wr_working <= 1'b1;
          o_wr_wnum    <= dst_addr_q[3:0];
        end else begin
          o_wr_addr    <= dst_addr_q;
          o_wr_working <= dst_dec[4];
          o_wr_wnum    <= dst_dec[3:0];
        end
      end
    end
  end

  // flags: an instruction completing wins over a software write
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_flags <= FLAGS_RESET;
    end else if (finish) begin
      o_flags <= core_flags;
    end else if (i_reg_wr && (i_reg_addr == REG_FLAGS)) begin
      o_flags <= i_reg_wdata & FLAGS_MASK;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_illegal <= 1'b0;
    end else begin
      o_illegal <= take_bad;
    end
  end

  // sticky illegal flag: a new refusal wins over a clear in the same cycle
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      illegal_sticky <= 1'b0;
    end else if (take_bad) begin
      illegal_sticky <= 1'b1;
    end else if (i_reg_wr && (i_reg_addr == REG_STATUS) && i_reg_wdata[STAT_ILLEGAL]) begin
      illegal_sticky <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      ctrl <= CTRL_RESET;
    end else if (i_reg_wr && (i_reg_addr == REG_CTRL)) begin
      ctrl <= {7'h00, i_reg_wdata[CTRL_ENABLE]};
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      if (i_reg_addr == REG_FLAGS) begin
        o_reg_rdata <= o_flags;
      end else if (i_reg_addr == REG_RESULT) begin
        o_reg_rdata <= result;
      end else if (i_reg_addr == REG_LAST_OP) begin
        o_reg_rdata <= last_op;
      end else if (i_reg_addr == REG_STATUS) begin
        o_reg_rdata <= {5'h00, last_add, illegal_sticky, o_busy};
      end else if (i_reg_addr == REG_CTRL) begin
        o_reg_rdata <= ctrl;
      end else begin
        o_reg_rdata <= 8'h00;
      end
    end else begin
      o_reg_rdata <= 8'h00;
    end
  end

  // checks
  logic add_done;
  logic and_done;
  logic [8:0] chk_sum9;
  logic [4:0] chk_low5;

  always_comb begin
    add_done = o_done && last_add;
    and_done = o_done && !last_add;
    chk_sum9 = {1'b0, dst_q} + {1'b0, src_q};
    chk_low5 = {1'b0, dst_q[3:0]} + {1'b0, src_q[3:0]};
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  sequence s_take_short;
    take_ok && (i_opcode[3:0] <= LO_R_IR);
  endsequence

  sequence s_take_long;
    take_ok && (i_opcode[3:0] > LO_R_IR);
  endsequence

  property p_short_timing;
    s_take_short |=> (!o_done && o_busy)[*6] ##1 (o_done && !o_busy);
  endproperty
  a_short_timing: assert property (p_short_timing)
    else $error("short form did not finish after 6 cycles");

  property p_long_timing;
    s_take_long |=> (!o_done)[*8] ##1 (!o_done)[*2] ##1 o_done;
  endproperty
  a_long_timing: assert property (p_long_timing)
    else $error("register form did not finish after 10 cycles");

  property p_add_result;
    add_done |-> (o_wr_data == chk_sum9[7:0]) && (result == o_wr_data);
  endproperty
  a_add_result: assert property (p_add_result)
    else $error("add result wrong");

  property p_dst_only;
    o_done && !dst_short_q |-> (o_wr_addr == dst_addr_q);
  endproperty
  a_dst_only: assert property (p_dst_only)
    else $error("write not aimed at destination");

  property p_carry;
    add_done |-> o_flags[FLAG_C] == (chk_sum9 > 9'h0ff);
  endproperty
  a_carry: assert property (p_carry)
    else $error("carry flag wrong after add");

  property p_zero;
    o_done |-> o_flags[FLAG_Z] == (o_wr_data == 8'h00);
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero flag wrong");

  property p_overflow;
    add_done |-> o_flags[FLAG_V] == ((dst_q[7] ~^ src_q[7]) & (o_wr_data[7] ^ dst_q[7]));
  endproperty
  a_overflow: assert property (p_overflow)
    else $error("overflow flag wrong after add");

  property p_add_sign;
    add_done |-> o_flags[FLAG_S] == chk_sum9[7];
  endproperty
  a_add_sign: assert property (p_add_sign)
    else $error("sign flag wrong after add");

  property p_half;
    add_done |-> o_flags[FLAG_H] == (chk_low5 > 5'h0f);
  endproperty
  a_half: assert property (p_half)
    else $error("half-carry flag wrong after add");

  property p_dadj;
    add_done |-> !o_flags[FLAG_D];
  endproperty
  a_dadj: assert property (p_dadj)
    else $error("decimal-adjust not cleared after add");

  property p_and_result;
    and_done |-> o_wr_data == (dst_q & src_q);
  endproperty
  a_and_result: assert property (p_and_result)
    else $error("and result wrong");

  property p_and_v;
    and_done |-> !o_flags[FLAG_V];
  endproperty
  a_and_v: assert property (p_and_v)
    else $error("overflow not cleared after and");

  property p_and_sign;
    and_done |-> o_flags[FLAG_S] == (dst_q[7] & src_q[7]);
  endproperty
  a_and_sign: assert property (p_and_sign)
    else $error("sign flag wrong after and");

  property p_and_keep;
    and_done |-> (o_flags[FLAG_C] == $past(o_flags[FLAG_C]))
              && (o_flags[FLAG_H] == $past(o_flags[FLAG_H]))
              && (o_flags[FLAG_D] == $past(o_flags[FLAG_D]));
  endproperty
  a_and_keep: assert property (p_and_keep)
    else $error("and disturbed carry, half-carry or decimal-adjust");

  property p_wreg;
    o_done |-> (o_wr_working == (o_wr_addr[7:4] == WORKING_NIBBLE))
            && (o_wr_wnum == o_wr_addr[3:0]);
  endproperty
  a_wreg: assert property (p_wreg)
    else $error("working register decode wrong");

endmodule

// [verif/alu_seq_model.sv]
`timescale 1ns/10ps
module alu_seq_model (
  input  wire logic       i_clk,
  input  wire logic       i_go,
  input  wire logic [7:0] i_opcode,
  input  wire logic [7:0] i_dst_addr,
  input  wire logic [7:0] i_src_addr,
  input  wire logic       i_done,
  input  wire logic [7:0] i_wr_addr,
  input  wire logic [7:0] i_wr_data,
  output logic            o_issue,
  output logic [7:0]      o_dst_data,
  output logic [7:0]      o_src_data
);
  logic [7:0] rf [256];
  logic       short_form;
  logic [7:0] src_loc;

  // working registers sit at e0..ef, the register pointer never moves
  function automatic logic [7:0] loc(input logic [7:0] a, input logic s);
    loc = (s || a[7:4] == 4'he) ? {4'he, a[3:0]} : a;
  endfunction

  assign short_form = (i_opcode[3:1] == 3'h1);
  assign src_loc    = loc(i_src_addr, short_form);
  assign o_dst_data = rf[loc(i_dst_addr, short_form)];

  always_comb begin
    case (i_opcode[3:0])
      4'h3, 4'h5: o_src_data = rf[rf[src_loc]];
      4'h6, 4'h7: o_src_data = i_src_addr;
      default:    o_src_data = rf[src_loc];
    endcase
  end

  initial o_issue = 1'b0;

  // the destination is the only location ever written back
  always @(posedge i_clk) begin
    o_issue <= i_go;
    if (i_done) begin
      rf[i_wr_addr] <= i_wr_data;
    end
  end
endmodule

// [verif/tb.sv]
`timescale 1ns/10ps
module tb;
  import byte_alu_pkg::*;
  logic       i_clk = 1'b0;
  logic       i_nrst, go, i_issue, o_busy, o_done, o_illegal;
  logic       o_wr_working, o_src_working, i_reg_wr, i_reg_rd;
  logic [7:0] i_opcode, i_dst_addr, i_src_addr, i_dst_data, i_src_data;
  logic [7:0] o_wr_addr, o_wr_data, o_flags, i_reg_wdata, o_reg_rdata, v;
  logic [3:0] o_wr_wnum, o_src_wnum, i_reg_addr;
  logic [31:0] seed = 32'h66ac;
  logic [31:0] r;
  int         n_fail = 0;
  int         n_checks = 0;
  logic [7:0] c_op [8] = '{8'h06, 8'h06, 8'h06, 8'h06, 8'h06, 8'h56, 8'h56, 8'h56};
  logic [7:0] c_d  [8] = '{8'h44, 8'h7f, 8'hff, 8'h80, 8'h0f, 8'hc3, 8'hf0, 8'h80};
  logic [7:0] c_s  [8] = '{8'h11, 8'h01, 8'h01, 8'h80, 8'h01, 8'h7b, 8'h0f, 8'hff};

  always #2.5 i_clk = ~i_clk;

  byte_add_and_alu u_byte_add_and_alu (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_issue(i_issue), .i_opcode(i_opcode),
    .i_dst_addr(i_dst_addr), .i_src_addr(i_src_addr), .i_dst_data(i_dst_data),
    .i_src_data(i_src_data), .o_busy(o_busy), .o_done(o_done), .o_illegal(o_illegal),
    .o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data), .o_wr_working(o_wr_working),
    .o_wr_wnum(o_wr_wnum), .o_src_working(o_src_working), .o_src_wnum(o_src_wnum),
    .o_flags(o_flags), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata));

  alu_seq_model u_alu_seq_model (
    .i_clk(i_clk), .i_go(go), .i_opcode(i_opcode), .i_dst_addr(i_dst_addr),
    .i_src_addr(i_src_addr), .i_done(o_done), .i_wr_addr(o_wr_addr),
    .i_wr_data(o_wr_data), .o_issue(i_issue), .o_dst_data(i_dst_data),
    .o_src_data(i_src_data));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [7:0] exp_flags(input logic [7:0] op, d, s, f);
    logic [8:0] sum;
    logic [7:0] q;
    sum = {1'b0, d} + {1'b0, s};
    q = sum[7:0];
    if (op[7:4] == ADD_HI) begin
      return {sum[8], q == 8'h00, q[7], (d[7] == s[7]) && (q[7] != d[7]), 1'b0,
              ({1'b0, d[3:0]} + {1'b0, s[3:0]}) > 5'h0f, 2'b00};
    end
    q = d & s;
    return {f[7], q == 8'h00, q[7], 1'b0, f[3], f[2], 2'b00};
  endfunction

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    i_reg_wr    <= 1'b1;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
    #1;
  endtask

  task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_reg_addr <= a;
    i_reg_rd   <= 1'b1;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    #1;
    d = o_reg_rdata;
  endtask

  // offers one instruction; returns just after the model raises issue
  task automatic offer(input logic [7:0] op, input logic [7:0] da, input logic [7:0] sa);
    @(posedge i_clk);
    i_opcode   <= op;
    i_dst_addr <= da;
    i_src_addr <= sa;
    go         <= 1'b1;
    @(posedge i_clk);
    go <= 1'b0;
    #1;
  endtask

  task automatic run(input logic [7:0] op, input logic [7:0] da, input logic [7:0] sa);
    logic [7:0] d, s, f, q;
    logic       w;
    int         n;
    int         nb;
    offer(op, da, sa);
    d = i_dst_data;
    s = i_src_data;
    f = o_flags;
    w = (op[3:1] == 3'h1);
    q = (op[7:4] == ADD_HI) ? d + s : d & s;
    n = -1;
    nb = 0;
    do begin
      @(posedge i_clk);
      #1;
      n++;
      nb += (o_busy === 1'b1);
    end while (o_done !== 1'b1 && n < 30);
    chk("cycles", 8'(n), w ? 8'(CYC_SHORT) : 8'(CYC_LONG));
    chk("busy", 8'(nb), w ? 8'(CYC_SHORT) : 8'(CYC_LONG));
    chk("result", o_wr_data, q);
    chk("flags", o_flags, exp_flags(op, d, s, f));
    chk("wr_addr", o_wr_addr, w ? {WORKING_NIBBLE, da[3:0]} : da);
    chk("wr_work", {3'h0, o_wr_working, o_wr_wnum},
        {3'h0, w || da[7:4] == WORKING_NIBBLE, da[3:0]});
    if (op[3:1] != 3'h3) begin
      chk("src_work", {3'h0, o_src_working, o_src_wnum},
          {3'h0, w || sa[7:4] == WORKING_NIBBLE, sa[3:0]});
    end
    reg_rd(REG_RESULT, v);
    chk("result reg", v, q);
  endtask

  task automatic stop_test();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #200000;
    n_fail++;
    stop_test();
  end

  initial begin
    {i_nrst, go, i_opcode, i_dst_addr, i_src_addr} = '0;
    {i_reg_addr, i_reg_wdata, i_reg_wr, i_reg_rd} = '0;
    repeat (16) @(posedge i_clk);
    i_nrst <= 1'b1;
    for (int a = 0; a < 6; a++) begin
      reg_rd(a == 5 ? 4'h9 : 4'(a), v);
      chk("reset reg", v, a == 4 ? CTRL_RESET : 8'h00);
    end
    reg_wr(4'h9, 8'hff);
    reg_rd(4'h9, v);
    chk("unmapped", v, 8'h00);
    reg_wr(REG_FLAGS, 8'hff);
    reg_rd(REG_FLAGS, v);
    chk("flags reg", v, FLAGS_MASK);
    $display("test registers done");
    for (int k = 0; k < 8; k++) begin
      reg_wr(REG_FLAGS, k[0] ? 8'hac : 8'h50);
      u_alu_seq_model.rf[8'h20] = c_d[k];
      run(c_op[k], 8'h20, c_s[k]);
      reg_rd(REG_LAST_OP, v);
      chk("last op", v, c_op[k]);
    end
    $display("test corners done");
    offer(8'h08, 8'he1, 8'h00);
    @(posedge i_clk);
    #1;
    chk("illegal", {7'h0, o_illegal}, 8'h01);
    reg_rd(REG_STATUS, v);
    chk("status", v & 8'h02, 8'h02);
    reg_wr(REG_STATUS, 8'h02);
    reg_rd(REG_STATUS, v);
    chk("status clr", v & 8'h02, 8'h00);
    // disabled block must ignore a valid offer
    reg_wr(REG_CTRL, 8'h00);
    offer(8'h02, 8'h01, 8'h02);
    @(posedge i_clk);
    #1;
    chk("disabled busy", {7'h0, o_busy}, 8'h00);
    reg_rd(REG_LAST_OP, v);
    chk("disabled op", v, c_op[7]);
    reg_wr(REG_CTRL, 8'h01);
    $display("test refusal done");
    for (int k = 0; k < 60; k++) begin
      r = rnd();
      if (r[4]) begin
        reg_wr(REG_FLAGS, r[7:0]);
      end
      repeat (r[3:2]) @(posedge i_clk);
      #1;
      for (int i = 0; i < 256; i++) begin
        u_alu_seq_model.rf[i] = 8'(rnd() >> 8);
      end
      run({r[9] ? AND_HI : ADD_HI, 4'(3'h2 + r[15:10] % 6)},
          r[24] ? {WORKING_NIBBLE, r[19:16]} : r[23:16], r[31:24]);
    end
    $display("test random done");
    stop_test();
  end
endmodule
